// File: core/leu_core.sv
`timescale 1ns/1ps
`default_nettype none
module leu_core #(
	parameter int ERR_W = leu_pkg::ERR_W,
	parameter int HDR_W = leu_pkg::HDR_W,
	parameter bit UNC_HDR_EN = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hardReset,
	input wire logic [ERR_W-1:0] uncErrIn,
	input wire logic [HDR_W-1:0] uncHdrIn,
	input wire logic intUncErr,
	input wire logic [ERR_W-1:0] uncMask,
	input wire logic [ERR_W-1:0] uncSeverity,
	input wire logic uncClrWr,
	input wire logic [ERR_W-1:0] uncClrData,
	input wire logic [ERR_W-1:0] corErrIn,
	input wire logic [HDR_W-1:0] corHdrIn,
	input wire logic intCorErr,
	input wire logic [ERR_W-1:0] corMask,
	input wire logic corClrWr,
	input wire logic [ERR_W-1:0] corClrData,
	input wire logic parityErr,
	input wire logic eccErr,
	input wire logic unexpCpl,
	input wire logic pmuErr,
	input wire logic wdtTimeout,
	input wire logic escClrWr,
	input wire logic [1:0] escClrData,
	input wire logic [2:0] memErrIn,
	input wire logic [2:0] rpErrIn,
	input wire logic [2:0] rootControl,
	output logic [ERR_W-1:0] uncStatus,
	output logic [ERR_W-1:0] uncFirst,
	output logic [ERR_W-1:0] uncNext,
	output logic [HDR_W-1:0] uncHdrLog,
	output logic uncHdrValid,
	output logic [ERR_W-1:0] corStatus,
	output logic [ERR_W-1:0] corFirst,
	output logic [ERR_W-1:0] corNext,
	output logic [HDR_W-1:0] corHdrLog,
	output logic corHdrValid,
	output logic [2:0] classOut,
	output logic [2:0] msgOut,
	output logic [2:0] evtFwdOut,
	output logic [2:0] memErrOut,
	output logic [1:0] escStatus,
	output logic machineCheckOut_n,
	output logic internalErrorOut_n,
	output logic platformResetOut_n
);

	////////////////////////////////////////////////////////////////////////
	// helpers
	// lowest set bit of a vector, one-hot
	function automatic logic [ERR_W-1:0] lowBit(input logic [ERR_W-1:0] v);
		lowBit = v & (~v + {{(ERR_W-1){1'b0}}, 1'b1});
	endfunction : lowBit
	logic [ERR_W-1:0] uncEv;
	logic [ERR_W-1:0] corEv;
	logic [ERR_W-1:0] uncVal;
	logic [ERR_W-1:0] corVal;
	logic [ERR_W-1:0] uncClr;
	logic [ERR_W-1:0] corClr;

	// fold endpoint internal errors into their fixed positions
	always_comb
	begin
		uncEv = uncErrIn;
		corEv = corErrIn;
		uncEv[leu_pkg::INT_UNC_BIT] = uncErrIn[leu_pkg::INT_UNC_BIT] | intUncErr;
		corEv[leu_pkg::INT_COR_BIT] = corErrIn[leu_pkg::INT_COR_BIT] | intCorErr;
	end

	// masked errors are dropped before any logging
	assign uncVal = uncEv & ~uncMask;
	assign corVal = corEv & ~corMask;
	// ones in the write data clear, zeros keep
	assign uncClr = uncClrWr ? uncClrData : leu_pkg::LOG_RST;
	assign corClr = corClrWr ? corClrData : leu_pkg::LOG_RST;

	////////////////////////////////////////////////////////////////////////
	// logging paths, one per class group
	logic [ERR_W-1:0] pathVal [2];
	logic [ERR_W-1:0] pathClr [2];
	logic [HDR_W-1:0] pathHdr [2];
	assign pathVal[leu_pkg::PATH_UNC] = uncVal;
	assign pathVal[leu_pkg::PATH_COR] = corVal;
	assign pathClr[leu_pkg::PATH_UNC] = uncClr;
	assign pathClr[leu_pkg::PATH_COR] = corClr;
	assign pathHdr[leu_pkg::PATH_UNC] = uncHdrIn;
	assign pathHdr[leu_pkg::PATH_COR] = corHdrIn;

	genvar p;
	generate
		for (p = 0; p < 2; p++)
		begin : gPath
			logic [ERR_W-1:0] status_r;
			logic [ERR_W-1:0] first_r;
			logic [ERR_W-1:0] next_r;
			logic [HDR_W-1:0] hdr_r;
			logic hdrValid_r;
			logic [ERR_W-1:0] firstKeep;
			logic [ERR_W-1:0] firstLoad;
			logic [ERR_W-1:0] rest;

			// first log is closed while any of its bits survive the clear
			always_comb
			begin
				firstKeep = first_r & ~pathClr[p];
				firstLoad = (firstKeep == '0) ? lowBit(pathVal[p]) : '0;
				rest = pathVal[p] & ~firstLoad & ~firstKeep;
			end

			// status: set wins over a clear in the same cycle
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
					status_r <= leu_pkg::LOG_RST;
				else
					status_r <= (status_r & ~pathClr[p]) | pathVal[p];
			end

			// first and next logs, cleared with the status bit
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					first_r <= leu_pkg::LOG_RST;
					next_r <= leu_pkg::LOG_RST;
				end
				else
				begin
					first_r <= firstKeep | firstLoad;
					next_r <= (next_r & ~pathClr[p]) | rest;
				end
			end

			// header captured only with a new first error; hard reset does not touch it
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					hdr_r <= leu_pkg::HDR_RST;
					hdrValid_r <= 1'b0;
				end
				else if (firstLoad != '0 && (p != leu_pkg::PATH_UNC || UNC_HDR_EN))
				begin
					hdr_r <= pathHdr[p];
					hdrValid_r <= 1'b1;
				end
				else if (firstKeep == '0)
					hdrValid_r <= 1'b0;
			end
		end
	endgenerate

	assign uncStatus = gPath[leu_pkg::PATH_UNC].status_r;
	assign uncFirst = gPath[leu_pkg::PATH_UNC].first_r;
	assign uncNext = gPath[leu_pkg::PATH_UNC].next_r;
	assign uncHdrLog = gPath[leu_pkg::PATH_UNC].hdr_r;
	assign uncHdrValid = gPath[leu_pkg::PATH_UNC].hdrValid_r;
	assign corStatus = gPath[leu_pkg::PATH_COR].status_r;
	assign corFirst = gPath[leu_pkg::PATH_COR].first_r;
	assign corNext = gPath[leu_pkg::PATH_COR].next_r;
	assign corHdrLog = gPath[leu_pkg::PATH_COR].hdr_r;
	assign corHdrValid = gPath[leu_pkg::PATH_COR].hdrValid_r;

	////////////////////////////////////////////////////////////////////////
	// class levels and messages toward the global logic
	logic [2:0] classOut_r;
	logic [2:0] class_nxt;
	logic [2:0] msgOut_r;
	logic [2:0] msg_nxt;
	logic [ERR_W-1:0] uncNew;

	// only bits not yet set count as a fresh message
	assign uncNew = uncVal & ~uncStatus;

	always_comb
	begin
		class_nxt[leu_pkg::SEV_COR] = |(corStatus & ~corMask);
		class_nxt[leu_pkg::SEV_NONFATAL] = |(uncStatus & ~uncMask & ~uncSeverity);
		class_nxt[leu_pkg::SEV_FATAL] = |(uncStatus & ~uncMask & uncSeverity);
		msg_nxt[leu_pkg::SEV_COR] = |(corVal & ~corStatus);
		msg_nxt[leu_pkg::SEV_NONFATAL] = |(uncNew & ~uncSeverity);
		msg_nxt[leu_pkg::SEV_FATAL] = |(uncNew & uncSeverity);
	end

	// registered so the levels never glitch toward the collector
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			classOut_r <= leu_pkg::CLASS_RST;
			msgOut_r <= leu_pkg::CLASS_RST;
		end
		else
		begin
			classOut_r <= class_nxt;
			msgOut_r <= msg_nxt;
		end
	end

	assign classOut = classOut_r;
	assign msgOut = msgOut_r;

	////////////////////////////////////////////////////////////////////////
	// collector forwarding, root ports, non-PCI path
	logic [2:0] evtFwd_r;
	logic [2:0] memErr_r;

	// root control gates both endpoint messages and root port errors
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			evtFwd_r <= leu_pkg::CLASS_RST;
		else
			evtFwd_r <= (msgOut_r | rpErrIn) & rootControl;
	end

	// memory controller style sources bypass the collector entirely
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			memErr_r <= leu_pkg::CLASS_RST;
		else
			memErr_r <= memErrIn;
	end

	assign evtFwdOut = evtFwd_r;
	assign memErrOut = memErr_r;

	////////////////////////////////////////////////////////////////////////
	// escalation status and pins
	logic [1:0] esc_r;
	logic [1:0] esc_nxt;
	logic [1:0] escSet;
	logic mchkOut_r;
	logic pltRst_r;
	leu_pkg::leu_esc_t ierrState_r;

	assign escSet[leu_pkg::ESC_MCHK] = parityErr | eccErr | unexpCpl;
	assign escSet[leu_pkg::ESC_IERR] = pmuErr | wdtTimeout;
	assign esc_nxt = (esc_r & ~(escClrWr ? escClrData : leu_pkg::ESC_RST)) | escSet;

	// sticky status, set wins over clear
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			esc_r <= leu_pkg::ESC_RST;
		else
			esc_r <= esc_nxt;
	end

	// pins follow the next status so an event shows on the same edge as the status
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			mchkOut_r <= 1'b1;
		else
			mchkOut_r <= ~esc_nxt[leu_pkg::ESC_MCHK];
	end

	// internal-error state; its one-hot idle bit is the active-low pin itself
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			ierrState_r <= leu_pkg::ESC_IDLE;
		else
		begin
			case (ierrState_r)
				leu_pkg::ESC_IDLE:
					if (esc_nxt[leu_pkg::ESC_IERR])
						ierrState_r <= leu_pkg::ESC_RAISED;
				leu_pkg::ESC_RAISED:
					if (!esc_nxt[leu_pkg::ESC_IERR])
						ierrState_r <= leu_pkg::ESC_IDLE;
				default:
					ierrState_r <= leu_pkg::ESC_IDLE;
			endcase
		end
	end

	// board must wait for this release before trusting the escalation pins
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			pltRst_r <= 1'b0;
		else
			pltRst_r <= ~hardReset;
	end

	assign escStatus = esc_r;
	assign machineCheckOut_n = mchkOut_r;
	assign internalErrorOut_n = ierrState_r[0]; // idle bit, high while no internal error
	assign platformResetOut_n = pltRst_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence twoFresh;
		(uncFirst == '0) && (uncClr == '0) && ($countones(uncVal) >= 2);
	endsequence
	sequence splitLogged;
		$onehot(uncFirst) && (uncNext != '0);
	endsequence
	statusSet_a: assert property ((uncVal != '0) |=>
		((uncStatus & $past(uncVal)) == $past(uncVal)))
		else $error("unmasked error did not set status");
	maskBlock_a: assert property (((uncStatus & ~$past(uncStatus)) & $past(uncMask)) == '0)
		else $error("masked error set status");
	firstHold_a: assert property (((uncFirst != '0) && ((uncClr & uncFirst) == '0)) |=>
		(uncFirst == $past(uncFirst)))
		else $error("first log changed while held");
	clearAll_a: assert property ((uncClr != '0) |=>
		(((uncStatus | uncFirst | uncNext) & $past(uncClr) & ~$past(uncVal)) == '0))
		else $error("clear left a log bit set");
	noRepeat_a: assert property (((uncNext & ~$past(uncNext)) & $past(uncFirst)
		& ~$past(uncClr)) == '0)
		else $error("repeat of first error logged in next");
	splitSame_a: assert property (twoFresh |=> splitLogged)
		else $error("simultaneous errors not split");
	fatalLevel_a: assert property ((uncStatus & ~uncMask & uncSeverity) != '0 |=>
		classOut[leu_pkg::SEV_FATAL])
		else $error("fatal class level missing");
	corLevel_a: assert property (classOut[leu_pkg::SEV_COR] ==
		(($past(corStatus) & ~$past(corMask)) != '0))
		else $error("correctable class level wrong");
	intBit_a: assert property ((intUncErr && !uncMask[leu_pkg::INT_UNC_BIT]) |=>
		uncStatus[leu_pkg::INT_UNC_BIT])
		else $error("internal error bit not set");
	mchkPin_a: assert property ((parityErr || eccErr || unexpCpl) |=>
		!machineCheckOut_n ##0 escStatus[leu_pkg::ESC_MCHK])
		else $error("machine check not raised");
	ierrPin_a: assert property ((pmuErr || wdtTimeout) |=> !internalErrorOut_n)
		else $error("internal error not raised");
	hardKeep_a: assert property ((hardReset && uncClr == '0) |=>
		((uncStatus & $past(uncStatus)) == $past(uncStatus)))
		else $error("hard reset disturbed status");

endmodule : leu_core
`default_nettype wire

// File: shared/leu_pkg.sv
package leu_pkg;
	// vector sizes for the local logging paths
	localparam int ERR_W = 32;
	localparam int HDR_W = 128;
	// fixed bit positions of the integrated endpoint internal errors
	localparam int INT_UNC_BIT = 22;
	localparam int INT_COR_BIT = 14;
	// path indices inside the generate loop
	localparam int PATH_UNC = 0;
	localparam int PATH_COR = 1;
	// severity class positions on three-bit class vectors
	localparam int SEV_COR = 0;
	localparam int SEV_NONFATAL = 1;
	localparam int SEV_FATAL = 2;
	// escalation status positions
	localparam int ESC_MCHK = 0;
	localparam int ESC_IERR = 1;
	// values after power-on reset
	localparam logic [ERR_W-1:0] LOG_RST = 32'h0000_0000;
	localparam logic [HDR_W-1:0] HDR_RST = 128'h0;
	localparam logic [2:0] CLASS_RST = 3'h0;
	localparam logic [1:0] ESC_RST = 2'h0;
	// level-type state of the internal-error pin
	typedef enum logic [1:0]
	{
		ESC_IDLE = 2'b01,
		ESC_RAISED = 2'b10
	} leu_esc_t;
endpackage : leu_pkg

// File: bench/leu_partner.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the global collector and board manager behind the block
module leu_partner (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic platformResetOut_n,
	input wire logic machineCheckOut_n,
	input wire logic internalErrorOut_n,
	input wire logic [2:0] evtFwdOut,
	input wire logic [2:0] memErrOut,
	output logic mchkSeen,
	output logic ierrSeen,
	output logic [2:0] globalSts
);
	logic mchkSeen_r;
	logic ierrSeen_r;
	logic [2:0] globalSts_r;
	////////////////////////////////////////////////////////////////////////////////
	// pins may glitch while platform reset is held, so they are not believed then
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mchkSeen_r <= 1'b0;
			ierrSeen_r <= 1'b0;
		end
		else if (platformResetOut_n)
		begin
			mchkSeen_r <= mchkSeen_r | !machineCheckOut_n;
			ierrSeen_r <= ierrSeen_r | !internalErrorOut_n;
		end
	end
	// class reports from forwarded messages and direct non-PCI sources
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			globalSts_r <= 3'h0;
		else
			globalSts_r <= globalSts_r | evtFwdOut | memErrOut;
	end
	assign mchkSeen = mchkSeen_r;
	assign ierrSeen = ierrSeen_r;
	assign globalSts = globalSts_r;
endmodule : leu_partner
`default_nettype wire

// File: bench/leu_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module leu_core_tb;
	localparam logic [127:0] HDR_A = 128'hA5A5_0001;
	localparam logic [127:0] HDR_B = 128'h5A5A_0002;
	localparam logic [127:0] HDR_C = 128'hC3C3_0003;
	logic coreClk = 1'b0;
	logic rstN = 1'b0;
	logic hardReset = 1'b0;
	logic intUncErr = 1'b0;
	logic intCorErr = 1'b0;
	logic uncClrWr = 1'b0;
	logic corClrWr = 1'b0;
	logic escClrWr = 1'b0;
	logic [31:0] uncErrIn = 32'h0;
	logic [31:0] uncMask = 32'h8;
	logic [31:0] uncSeverity = 32'h1;
	logic [31:0] uncClrData = 32'h0;
	logic [31:0] corErrIn = 32'h0;
	logic [31:0] corMask = 32'h1;
	logic [31:0] corClrData = 32'h0;
	logic [127:0] uncHdrIn = 128'h0;
	logic [127:0] corHdrIn = 128'h0;
	logic [4:0] escSrc = 5'h0;
	logic [1:0] escClrData = 2'h0;
	logic [2:0] memErrIn = 3'h0;
	logic [2:0] rpErrIn = 3'h0;
	logic [2:0] rootControl = 3'h7;
	logic [31:0] uncStatus, uncFirst, uncNext, corStatus, corFirst, corNext;
	logic [127:0] uncHdrLog, corHdrLog;
	logic uncHdrValid, corHdrValid, mchkN, ierrN, pltRstN, mchkSeen, ierrSeen;
	logic [2:0] classOut, msgOut, evtFwdOut, memErrOut, globalSts;
	logic [1:0] escStatus;
	int errorCnt = 0;
	int testsRun = 0;
	////////////////////////////////////////////////////////////////////////////////
	initial forever #5 coreClk = ~coreClk;
	leu_core u_dut (.core_clk(coreClk), .rst_n(rstN), .hardReset, .uncErrIn, .uncHdrIn,
		.intUncErr, .uncMask, .uncSeverity, .uncClrWr, .uncClrData, .corErrIn, .corHdrIn,
		.intCorErr, .corMask, .corClrWr, .corClrData, .parityErr(escSrc[0]),
		.eccErr(escSrc[1]), .unexpCpl(escSrc[2]), .pmuErr(escSrc[3]),
		.wdtTimeout(escSrc[4]), .escClrWr, .escClrData, .memErrIn, .rpErrIn, .rootControl,
		.uncStatus, .uncFirst, .uncNext, .uncHdrLog, .uncHdrValid, .corStatus, .corFirst,
		.corNext, .corHdrLog, .corHdrValid, .classOut, .msgOut, .evtFwdOut, .memErrOut,
		.escStatus, .machineCheckOut_n(mchkN), .internalErrorOut_n(ierrN),
		.platformResetOut_n(pltRstN));
	leu_partner u_partner (.core_clk(coreClk), .rst_n(rstN), .platformResetOut_n(pltRstN),
		.machineCheckOut_n(mchkN), .internalErrorOut_n(ierrN), .evtFwdOut, .memErrOut,
		.mchkSeen, .ierrSeen, .globalSts);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
		testsRun++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	// ends every pulse but hardReset and memErrIn at the sampling edge, then lets that edge's updates land
	task automatic fire;
		@(posedge coreClk);
		uncErrIn <= 32'h0;
		corErrIn <= 32'h0;
		intUncErr <= 1'b0;
		intCorErr <= 1'b0;
		uncClrWr <= 1'b0;
		corClrWr <= 1'b0;
		escClrWr <= 1'b0;
		escSrc <= 5'h0;
		rpErrIn <= 3'h0;
		#1;
	endtask : fire
	task automatic oneMore;
		@(posedge coreClk);
		#1;
	endtask : oneMore
	task automatic giveVerdict;
		$display("comparisons %0d, mismatches %0d", testsRun, errorCnt);
		if (errorCnt == 0 && testsRun > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : giveVerdict
	////////////////////////////////////////////////////////////////////////////////
	// two errors in one cycle, then repeats and a masked one
	task automatic uncLogging;
		@(posedge coreClk);
		uncErrIn <= 32'h5;
		uncHdrIn <= HDR_A;
		fire;
		chk("uncStatus", uncStatus, 32'h5);
		chk("uncFirst", uncFirst, 32'h1);
		chk("uncNext", uncNext, 32'h4);
		chk("uncHdrLog", uncHdrLog, HDR_A);
		chk("uncHdrValid", uncHdrValid, 1'b1);
		chk("msgOut", msgOut, 3'h6);
		oneMore;
		chk("classOut", classOut, 3'h6);
		chk("evtFwdOut", evtFwdOut, 3'h6);
		@(posedge coreClk);
		uncErrIn <= 32'h3;
		uncHdrIn <= HDR_B;
		fire;
		chk("uncNext repeat", uncNext, 32'h6);
		chk("uncFirst held", uncFirst, 32'h1);
		chk("uncHdrLog held", uncHdrLog, HDR_A);
		chk("partner globalSts cls", globalSts, 3'h6);
		@(posedge coreClk);
		uncErrIn <= 32'h8;
		fire;
		chk("uncStatus masked", uncStatus, 32'h7);
		chk("uncNext masked", uncNext, 32'h6);
		chk("msgOut masked", msgOut, 3'h0);
	endtask : uncLogging
	// hard reset must leave the logs alone
	task automatic hardResetHold;
		@(posedge coreClk);
		hardReset <= 1'b1;
		oneMore;
		chk("pltRstN low", pltRstN, 1'b0);
		chk("uncStatus sticky", uncStatus, 32'h7);
		chk("uncFirst sticky", uncFirst, 32'h1);
		@(posedge coreClk);
		hardReset <= 1'b0;
		oneMore;
		chk("pltRstN high", pltRstN, 1'b1);
	endtask : hardResetHold
	// write-one-to-clear in three steps, the first writing only zeros
	task automatic uncClear;
		int i;
		logic [31:0] data [3] = '{32'h0, 32'h1, 32'h6};
		logic [31:0] stat [3] = '{32'h7, 32'h6, 32'h0};
		logic [31:0] nxt [3] = '{32'h6, 32'h6, 32'h0};
		for (i = 0; i < 3; i++)
		begin
			@(posedge coreClk);
			uncClrWr <= 1'b1;
			uncClrData <= data[i];
			fire;
			chk("uncStatus clr", uncStatus, stat[i]);
			chk("uncNext clr", uncNext, nxt[i]);
			chk("uncFirst clr", uncFirst, (i == 0) ? 32'h1 : 32'h0);
			chk("uncHdrValid clr", uncHdrValid, i == 0);
		end
		oneMore;
		chk("classOut clear", classOut, 3'h0);
	endtask : uncClear
	// internal errors of the endpoint on their fixed bits, with a masked partner
	task automatic internalErrors;
		@(posedge coreClk);
		intCorErr <= 1'b1;
		corErrIn <= 32'h1;
		corHdrIn <= HDR_C;
		fire;
		chk("corStatus", corStatus, 32'h4000);
		chk("corFirst", corFirst, 32'h4000);
		chk("corNext", corNext, 32'h0);
		chk("corHdrLog", corHdrLog, HDR_C);
		chk("msgOut cor", msgOut, 3'h1);
		@(posedge coreClk);
		corClrWr <= 1'b1;
		corClrData <= 32'h4000;
		intUncErr <= 1'b1;
		fire;
		chk("corStatus clr", corStatus, 32'h0);
		chk("corHdrValid clr", corHdrValid, 1'b0);
		chk("uncStatus int", uncStatus, 32'h40_0000);
		chk("msgOut nonfatal", msgOut, 3'h2);
		@(posedge coreClk);
		uncClrWr <= 1'b1;
		uncClrData <= 32'h40_0000;
		fire;
		chk("uncStatus int clr", uncStatus, 32'h0);
	endtask : internalErrors
	// every escalation source, each cleared before the next
	task automatic escalations;
		int i;
		for (i = 0; i < 5; i++)
		begin
			@(posedge coreClk);
			escSrc <= 5'h1 << i;
			fire;
			chk("escStatus", escStatus, (i < 3) ? 2'h1 : 2'h2);
			chk("mchkN", mchkN, i >= 3);
			chk("ierrN", ierrN, i < 3);
			@(posedge coreClk);
			escClrWr <= 1'b1;
			escClrData <= 2'h3;
			fire;
			chk("escStatus clr", escStatus, 2'h0);
			chk("mchkN idle", mchkN, 1'b1);
		end
		chk("partner mchk", mchkSeen, 1'b1);
		chk("partner ierr", ierrSeen, 1'b1);
	endtask : escalations
	// direct non-PCI report and root port forwarding under the enables
	task automatic forwarding;
		@(posedge coreClk);
		memErrIn <= 3'h5;
		rpErrIn <= 3'h3;
		rootControl <= 3'h1;
		fire;
		chk("memErrOut", memErrOut, 3'h5);
		chk("evtFwdOut", evtFwdOut, 3'h1);
		oneMore;
		chk("partner globalSts", globalSts, 3'h7);
	endtask : forwarding
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge coreClk);
		#1;
		chk("pltRstN in reset", pltRstN, 1'b0);
		chk("mchkN in reset", mchkN, 1'b1);
		@(posedge coreClk);
		rstN <= 1'b1;
		uncLogging();
		hardResetHold();
		uncClear();
		internalErrors();
		escalations();
		forwarding();
		giveVerdict();
	end
	// bounded run; running out counts as a mismatch
	initial
	begin
		repeat (3000) @(posedge coreClk);
		errorCnt++;
		$display("run limit reached");
		giveVerdict();
	end
endmodule : leu_core_tb
`default_nettype wire
